/* File: bench/acs_asserts.sv */
`timescale 1ns/1ps

module acs_asserts
    import acs_pkg::*;
#(
    parameter bit LARGE_FLASH = 1'b0
)
(
    // Clock and reset
    input wire logic clock_in,
    input wire logic reset_in,
    // Configuration
    input wire logic enable_in,
    input wire logic auto_repeat_mode_in,
    input wire logic [PRE_W-1:0] prescaler_select_in,
    input wire logic [DLY_W-1:0] sample_delay_field_in,
    input wire logic [LEN_W-1:0] sample_length_field_in,
    input wire logic [WIN_W-1:0] window_mode_field_in,
    input wire logic [1:0] irq_enable_register_in,
    // Watched outputs
    input wire logic [MUX_W-1:0] active_input_select_out,
    input wire logic core_sample_out,
    input wire logic conversion_trigger_bit_out,
    input wire logic [1:0] pending_flags_register_out,
    input wire logic irq_request_out,
    input wire logic [7:0] irq_vector_out
);
    logic [15:0] samp_cnt;
    logic [15:0] next_samp_cnt;
    logic [15:0] samp_len;

    default clocking @(posedge clock_in); endclocking
    default disable iff (reset_in);

    // Counts clocks spent in the sampling phase.
    always_comb
    begin
        next_samp_cnt = core_sample_out ? samp_cnt + 16'h0001 : 16'h0000;
        samp_len = (16'(SAMPLE_BASE) + 16'(sample_delay_field_in)
            + 16'(sample_length_field_in)) << (32'(prescaler_select_in) + 1);
    end

    always_ff @(posedge clock_in)
    begin
        samp_cnt <= reset_in ? 16'h0000 : next_samp_cnt;
    end

    a_sample_length: assert property ($fell(core_sample_out) && enable_in
        |-> samp_cnt == samp_len) else $error("sampling phase length wrong");
    a_sel_frozen: assert property (core_sample_out && $past(core_sample_out)
        |-> $stable(active_input_select_out)) else $error("selection moved in sampling");
    a_trig_single: assert property ($rose(pending_flags_register_out[0])
        && !auto_repeat_mode_in |-> !conversion_trigger_bit_out)
        else $error("trigger bit kept after single result");
    a_auto_restart: assert property ($rose(pending_flags_register_out[0])
        && auto_repeat_mode_in && conversion_trigger_bit_out |-> core_sample_out)
        else $error("free run did not restart");
    a_win_off: assert property (window_mode_field_in == WIN_OFF
        && $past(window_mode_field_in) == WIN_OFF |-> !$rose(pending_flags_register_out[1]))
        else $error("window flag with comparator off");
    a_irq_raise: assert property ($stable(irq_enable_register_in) |-> irq_request_out
        == ((pending_flags_register_out & irq_enable_register_in) != 2'h0))
        else $error("request does not follow flags");
    a_vector_pick: assert property ($stable(pending_flags_register_out)
        && pending_flags_register_out != 2'h0 |-> irq_vector_out ==
        (pending_flags_register_out[0] ? VEC_RESULT : (LARGE_FLASH ? VEC_WIN_LARGE
        : VEC_WIN_SMALL))) else $error("vector offset wrong");
    a_start_soon: assert property ($rose(conversion_trigger_bit_out) && enable_in
        |-> ##[1:600] core_sample_out) else $error("conversion did not start");
endmodule // acs_asserts

bind acs_sequencer acs_asserts #(.LARGE_FLASH(LARGE_FLASH)) u_asserts (.*);

/* File: bench/acs_core_model.sv */
`timescale 1ns/1ps

// Converter core: channel n carries n times 40 mV.
module acs_core_model
    import acs_pkg::*;
(
    // Selection and phase
    input wire logic [MUX_W-1:0] select_in,
    input wire logic ref_internal_in,
    input wire logic busy_in,
    input wire logic hold_in,
    // Result
    output logic [CODE_W-1:0] data_out,
    output logic over_out
);
    int vin = 0;
    int vref = 3300;
    logic [CODE_W-1:0] code;

    // The sampled input is held through conversion, as a sample-and-hold does.
    always @*
    begin
        if (!hold_in)
        begin
            vin = 40 * int'(select_in);
            vref = ref_internal_in ? 1100 : 3300;
        end
        code = CODE_W'((1023 * vin) / vref);
        over_out = busy_in && (vin > vref);
        data_out = busy_in ? code : ~code;
    end
endmodule // acs_core_model

/* File: bench/adc_conversion_sequencer_tb_top.sv */
`timescale 1ns/1ps

module adc_conversion_sequencer_tb_top;
    import acs_pkg::*;
    typedef struct packed {
        logic [MUX_W-1:0] ch;
        logic [REF_W-1:0] rf;
        logic r8;
        logic [WIN_W-1:0] wm;
        logic [RES_W-1:0] lo;
        logic [RES_W-1:0] hi;
        logic [RES_W-1:0] res;
        logic wf;
        logic ts;
    } acs_row_t;
    logic clock_in, reset_in, enable_in, auto_repeat_mode_in, resolution_select_bit_in;
    logic trigger_write_in, trigger_stop_in, result_read_in, event_in, event_trigger_enable_in;
    logic core_over_range_in, reference_internal_out, temp_sensor_enable_out;
    logic core_sample_out, core_convert_out, conversion_trigger_bit_out;
    logic irq_result_ready_out, irq_window_out, irq_request_out;
    logic [ACC_W-1:0] sample_count_select_in;
    logic [PRE_W-1:0] prescaler_select_in;
    logic [DLY_W-1:0] sample_delay_field_in;
    logic [LEN_W-1:0] sample_length_field_in;
    logic [MUX_W-1:0] input_select_field_in, active_input_select_out;
    logic [REF_W-1:0] reference_select_field_in, active_reference_select_out;
    logic [WIN_W-1:0] window_mode_field_in;
    logic [RES_W-1:0] window_low_threshold_in, window_high_threshold_in, converted_value_out;
    logic [1:0] irq_enable_register_in, flag_clear_in, pending_flags_register_out;
    logic [CODE_W-1:0] core_data_in;
    logic [7:0] irq_vector_out;
    int errors = 0;
    int samples_checked = 0;
    int n;
    acs_row_t rows [6] = '{
        '{5'h05, 2'h0, 1'b0, 3'h1, 16'h0100, 16'h0000, 16'h00ba, 1'b1, 1'b0},
        '{5'h0a, 2'h1, 1'b1, 3'h2, 16'h0000, 16'h0010, 16'h001f, 1'b1, 1'b0},
        '{5'h1e, 2'h0, 1'b0, 3'h3, 16'h0010, 16'h0020, 16'h03ff, 1'b0, 1'b1},
        '{5'h14, 2'h0, 1'b0, 3'h4, 16'h0100, 16'h0200, 16'h02e8, 1'b1, 1'b0},
        '{5'h0f, 2'h1, 1'b0, 3'h0, 16'hffff, 16'h0000, 16'h00ba, 1'b0, 1'b0},
        '{5'h0c, 2'h1, 1'b0, 3'h3, 16'h0080, 16'h00a0, 16'h0094, 1'b1, 1'b0}
    };

    acs_sequencer #(.LARGE_FLASH(1'b0)) u_dut (.*);

    acs_core_model u_core (
        .select_in(active_input_select_out),
        .ref_internal_in(reference_internal_out),
        .busy_in(core_sample_out | core_convert_out),
        .hold_in(core_convert_out),
        .data_out(core_data_in),
        .over_out(core_over_range_in)
    );

    initial
    begin
        clock_in = 1'b0;
        forever #12.5 clock_in = ~clock_in;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            errors++;
            $display("CHECK FAILED at %0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic strobe(ref logic s);
        s = 1'b1;
        @(negedge clock_in);
        s = 1'b0;
    endtask

    task automatic wait_flag(output int cnt);
        cnt = 0;
        while (pending_flags_register_out[0] !== 1'b1 && cnt < 3000)
        begin
            @(negedge clock_in);
            cnt++;
        end
    endtask

    task automatic report_and_stop();
        $display("Checks %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    initial
    begin
        {enable_in, auto_repeat_mode_in, resolution_select_bit_in, trigger_write_in} = '0;
        {trigger_stop_in, result_read_in, event_in, event_trigger_enable_in} = '0;
        {sample_count_select_in, prescaler_select_in, sample_delay_field_in} = '0;
        {sample_length_field_in, input_select_field_in, reference_select_field_in} = '0;
        {window_mode_field_in, window_low_threshold_in, window_high_threshold_in} = '0;
        {irq_enable_register_in, flag_clear_in} = '0;
        reset_in = 1'b1;
        repeat (6) @(negedge clock_in);
        reset_in = 1'b0;
        check(pending_flags_register_out, 2'h0);
        check(reference_internal_out, 1'b1);
        enable_in = 1'b1;
        for (int i = 0; i < 6; i++)
        begin
            input_select_field_in = rows[i].ch;
            reference_select_field_in = rows[i].rf;
            resolution_select_bit_in = rows[i].r8;
            window_mode_field_in = rows[i].wm;
            window_low_threshold_in = rows[i].lo;
            window_high_threshold_in = rows[i].hi;
            irq_enable_register_in = (i == 0) ? 2'h0 : 2'h3;
            repeat (2) @(negedge clock_in);
            check(temp_sensor_enable_out, rows[i].ts);
            check(reference_internal_out, rows[i].rf == REF_INTERNAL);
            strobe(trigger_write_in);
            wait_flag(n);
            check(n, 28);
            check(converted_value_out, rows[i].res);
            check(pending_flags_register_out[1], rows[i].wf);
            check(conversion_trigger_bit_out, 1'b0);
            @(negedge clock_in);
            check(irq_request_out, i != 0);
            flag_clear_in = {1'b1, i[0]};
            result_read_in = !i[0];
            @(negedge clock_in);
            {flag_clear_in, result_read_in} = '0;
            check(pending_flags_register_out, 2'h0);
        end
        // Longer sampling, with a channel change during the sampling phase.
        // long sampling fields
        input_select_field_in = 5'h05;
        reference_select_field_in = 2'h0;
        window_mode_field_in = WIN_OFF;
        sample_delay_field_in = 4'h3;
        sample_length_field_in = 5'h05;
        repeat (2) @(negedge clock_in);
        strobe(trigger_write_in);
        repeat (8) @(negedge clock_in);
        input_select_field_in = 5'h14;
        wait_flag(n);
        check(n + 8, 44);
        check(converted_value_out, 16'h00ba);
        strobe(result_read_in);
        check(active_input_select_out, 5'h14);
        // Free run: period, late channel change, stop.
        {sample_delay_field_in, sample_length_field_in} = '0;
        input_select_field_in = 5'h05;
        auto_repeat_mode_in = 1'b1;
        repeat (2) @(negedge clock_in);
        strobe(trigger_write_in);
        wait_flag(n);
        input_select_field_in = 5'h14;
        strobe(result_read_in);
        wait_flag(n);
        check(n, 25);
        check(converted_value_out, 16'h00ba);
        strobe(result_read_in);
        wait_flag(n);
        check(converted_value_out, 16'h02e8);
        strobe(trigger_stop_in);
        strobe(result_read_in);
        wait_flag(n);
        strobe(result_read_in);
        repeat (60) @(negedge clock_in);
        check(pending_flags_register_out[0], 1'b0);
        auto_repeat_mode_in = 1'b0;
        // Events start conversions only when enabled.
        event_in = 1'b1;
        repeat (60) @(negedge clock_in);
        check(pending_flags_register_out[0], 1'b0);
        event_in = 1'b0;
        event_trigger_enable_in = 1'b1;
        repeat (4) @(negedge clock_in);
        event_in = 1'b1;
        wait_flag(n);
        check(n, 31);
        check(converted_value_out, 16'h02e8);
        {event_in, event_trigger_enable_in} = '0;
        strobe(result_read_in);
        // Four accumulated samples at a slower converter clock.
        sample_count_select_in = 3'h2;
        prescaler_select_in = 3'h1;
        sample_delay_field_in = 4'h2;
        sample_length_field_in = 5'h03;
        input_select_field_in = 5'h05;
        window_mode_field_in = WIN_ABOVE;
        window_high_threshold_in = 16'h0200;
        repeat (2) @(negedge clock_in);
        strobe(trigger_write_in);
        wait_flag(n);
        check(converted_value_out, 16'h02e8);
        check(pending_flags_register_out, 2'h3);
        strobe(result_read_in);
        check(irq_vector_out, VEC_WIN_SMALL);
        check(irq_window_out, 1'b1);
        check(irq_result_ready_out, 1'b0);
        check(active_reference_select_out, REF_INTERNAL);
        report_and_stop();
    end

    initial
    begin
        repeat (8000) @(posedge clock_in);
        errors++;
        report_and_stop();
    end
endmodule // adc_conversion_sequencer_tb_top

/* File: verilog/acs_pkg.sv */
package acs_pkg;

    // Field widths.
    localparam int CODE_W = 10;
    localparam int RES_W = 16;
    localparam int MUX_W = 5;
    localparam int REF_W = 2;
    localparam int DLY_W = 4;
    localparam int LEN_W = 5;
    localparam int WIN_W = 3;
    localparam int ACC_W = 3;
    localparam int PRE_W = 3;
    localparam int CYC_W = 6;
    localparam int DIV_W = 8;
    localparam int ACNT_W = 7;

    // Conversion timing in converter clock cycles.
    localparam logic [CYC_W-1:0] SAMPLE_BASE = 6'h02;
    localparam logic [CYC_W-1:0] CONV_CYCLES = 6'h0d;
    localparam logic [CYC_W-1:0] CYC_ONE = 6'h01;

    // Codes and selections.
    localparam logic [CODE_W-1:0] MAX_CODE = 10'h3ff;
    localparam logic [REF_W-1:0] REF_INTERNAL = 2'h0;
    localparam logic [MUX_W-1:0] TEMP_CHANNEL = 5'h1e;
    localparam logic [RES_W-1:0] RES_RESET = 16'h0000;
    localparam logic [DIV_W-1:0] DIV_FULL = 8'hff;

    // Window compare conditions.
    localparam logic [WIN_W-1:0] WIN_OFF = 3'h0;
    localparam logic [WIN_W-1:0] WIN_BELOW = 3'h1;
    localparam logic [WIN_W-1:0] WIN_ABOVE = 3'h2;
    localparam logic [WIN_W-1:0] WIN_INSIDE = 3'h3;
    localparam logic [WIN_W-1:0] WIN_OUTSIDE = 3'h4;

    // Pending flag bit positions.
    localparam int FLAG_RESULT_READY_FLAG = 0;
    localparam int FLAG_WIN = 1;

    // Interrupt vector offsets.
    localparam logic [7:0] VEC_RESULT = 8'h00;
    localparam logic [7:0] VEC_WIN_SMALL = 8'h02;
    localparam logic [7:0] VEC_WIN_LARGE = 8'h04;

    // Sequencer states, Gray coded along idle, sample, convert.
    typedef enum logic [1:0] {
        ACS_IDLE = 2'b00,
        ACS_SAMPLE = 2'b01,
        ACS_CONVERT = 2'b11
    } acs_state_t;

endpackage

/* File: verilog/acs_prescaler.sv */
`timescale 1ns/1ps

// Makes one-cycle ticks that stand for rising edges of the converter clock.
module acs_prescaler
    import acs_pkg::*;
(
    // Clock and reset
    input wire logic clock_in,
    input wire logic reset_in,
    // Control
    input wire logic run_in,
    input wire logic [PRE_W-1:0] presc_sel_in,
    // Tick
    output logic tick_out
);

    logic [DIV_W-1:0] count;
    logic [DIV_W-1:0] next_count;
    logic [DIV_W-1:0] terminal;

    // Division factor is two to the power of one more than the select.
    assign terminal = DIV_FULL >> (3'h7 - presc_sel_in);
    assign tick_out = run_in && (count == terminal);

    // The counter is held at zero while nothing is pending or running.
    always_comb
    begin
        next_count = '0;
        if (run_in && count != terminal)
        begin
            next_count = count + 8'h01;
        end
    end

    always_ff @(posedge clock_in)
    begin
        if (reset_in)
        begin
            count <= '0;
        end
        else
        begin
            count <= next_count;
        end
    end

endmodule // acs_prescaler

/* File: verilog/acs_sequencer.sv */
`timescale 1ns/1ps

// Behaviour
// [R1] Sampling lasts two plus sample delay plus sample length converter cycles.
// [R2] Auto-repeat restarts at once while trigger set; period thirteen plus delay plus length.
// [R3] Channel and reference selections copy continuously from shadow until conversion start.
// [R4] Selections freeze at start; copying resumes in the final cycle before ready. The code also copies in the final cycle of each accumulated sample.
// [R5] Conversion begins on next converter clock rising edge after trigger write.
// [R6] Software selects channel before triggering, changes it one cycle after trigger.
// [R7] In auto-repeat, late channel change affects only results after the next one. With accumulation the code applies it from the next result's second sample.
// [R8] Input above reference yields maximum code 0x3FF.
// [R9] Reference select value zero picks internal reference, otherwise supply.
// [R10] Selecting the temperature channel switches the temperature sensor on.
// [R11] Converted value holds the result whenever result ready is set.
// [R12] Software sets long initial delay, sample length and capacitance for temperature.
// [R13] Window compare supports below, above, inside and outside conditions.
// [R14] Window compare active only with non-zero mode, which picks the condition.
// [R15] With accumulation, compare only after the last sample, one flag per result.
// [R16] With event trigger enabled, an incoming event starts a conversion.
// [R17] Result vector offset 0x00; window vector 0x02 small or 0x04 large.
// [R18] Each condition sets its pending flag regardless of its enable.
// [R19] Interrupt request stands while flag and enable are both set.
// [R20] Plain conversion lasts thirteen cycles; sample-and-hold two cycles after start.
// [R21] Result ready clears on converted value read or on writing one.
// [R22] In single mode hardware clears the trigger bit when conversion finishes.
// [R23] Eight-bit resolution drops the two lowest result bits before accumulation.
module acs_sequencer
    import acs_pkg::*;
#(
    parameter bit LARGE_FLASH = 1'b0
)
(
    // Clock and reset
    input wire logic clock_in,
    input wire logic reset_in,
    // Configuration
    input wire logic enable_in,
    input wire logic auto_repeat_mode_in,
    input wire logic resolution_select_bit_in,
    input wire logic [ACC_W-1:0] sample_count_select_in,
    input wire logic [PRE_W-1:0] prescaler_select_in,
    input wire logic [DLY_W-1:0] sample_delay_field_in,
    input wire logic [LEN_W-1:0] sample_length_field_in,
    input wire logic [MUX_W-1:0] input_select_field_in,
    input wire logic [REF_W-1:0] reference_select_field_in,
    input wire logic [WIN_W-1:0] window_mode_field_in,
    input wire logic [RES_W-1:0] window_low_threshold_in,
    input wire logic [RES_W-1:0] window_high_threshold_in,
    input wire logic event_trigger_enable_in,
    input wire logic [1:0] irq_enable_register_in,
    // Software strobes
    input wire logic trigger_write_in,
    input wire logic trigger_stop_in,
    input wire logic result_read_in,
    input wire logic [1:0] flag_clear_in,
    // Event input from outside the clock domain
    input wire logic event_in,
    // Converter core
    input wire logic [CODE_W-1:0] core_data_in,
    input wire logic core_over_range_in,
    output logic [MUX_W-1:0] active_input_select_out,
    output logic [REF_W-1:0] active_reference_select_out,
    output logic reference_internal_out,
    output logic temp_sensor_enable_out,
    output logic core_sample_out,
    output logic core_convert_out,
    // Status
    output logic conversion_trigger_bit_out,
    output logic [RES_W-1:0] converted_value_out,
    output logic [1:0] pending_flags_register_out,
    output logic irq_result_ready_out,
    output logic irq_window_out,
    output logic irq_request_out,
    output logic [7:0] irq_vector_out
);

    acs_state_t state;
    acs_state_t next_state;
    logic [CYC_W-1:0] cycle;
    logic [CYC_W-1:0] next_cycle;
    logic [ACNT_W-1:0] acc_count;
    logic [ACNT_W-1:0] next_acc_count;
    logic [RES_W-1:0] acc;
    logic [RES_W-1:0] next_acc;
    logic trig_bit;
    logic next_trig_bit;
    logic [1:0] flags;
    logic [1:0] next_flags;
    logic [RES_W-1:0] result;
    logic [RES_W-1:0] next_result;
    logic [MUX_W-1:0] active_mux;
    logic [MUX_W-1:0] next_active_mux;
    logic [REF_W-1:0] active_ref;
    logic [REF_W-1:0] next_active_ref;
    logic irq_res;
    logic irq_win;
    logic irq_any;
    logic [7:0] irq_vec;
    logic next_irq_res;
    logic next_irq_win;
    logic [7:0] next_irq_vec;
    logic event_meta;
    logic event_sync;
    logic event_prev;
    logic event_edge;
    logic tick;
    logic running;
    logic [CYC_W-1:0] sample_total;
    logic [CYC_W-1:0] last_cycle;
    logic [ACNT_W-1:0] acc_last;
    logic [CODE_W-1:0] code;
    logic [RES_W-1:0] sample_value;
    logic [RES_W-1:0] acc_sum;
    logic win_hit;
    logic finish;
    logic result_done;
    logic trig_set;
    logic [7:0] win_vector;

    // Event input passes two flip-flops before the edge detector.
    always_ff @(posedge clock_in)
    begin
        if (reset_in)
        begin
            event_meta <= 1'b0;
            event_sync <= 1'b0;
            event_prev <= 1'b0;
        end
        else
        begin
            event_meta <= event_in;
            event_sync <= event_meta;
            event_prev <= event_sync;
        end
    end

    assign event_edge = event_sync && !event_prev;

    assign running = (state != ACS_IDLE);

    // [R5] start on tick
    acs_prescaler u_prescaler (
        .clock_in(clock_in),
        .reset_in(reset_in),
        .run_in(enable_in && (trig_bit || running)),
        .presc_sel_in(prescaler_select_in),
        .tick_out(tick)
    );

    // [R1] sampling length
    assign sample_total = SAMPLE_BASE + CYC_W'(sample_delay_field_in)
        + CYC_W'(sample_length_field_in);
    // [R20] thirteen-cycle base
    assign last_cycle = sample_total + (CONV_CYCLES - SAMPLE_BASE) - CYC_ONE;

    assign acc_last = ACNT_W'((8'h01 << sample_count_select_in) - 8'h01);
    assign finish = running && tick && (cycle == last_cycle);
    assign result_done = finish && (acc_count == acc_last);

    // [R8] saturate to maximum code
    assign code = core_over_range_in ? MAX_CODE : core_data_in;

    // [R23] eight-bit truncation
    assign sample_value = resolution_select_bit_in ?
        RES_W'(code[CODE_W-1:2]) : RES_W'(code);

    assign acc_sum = ((acc_count == '0) ? RES_RESET : acc) + sample_value;

    // [R13] four window conditions
    always_comb
    begin
        win_hit = 1'b0;
        case (window_mode_field_in)
            WIN_BELOW: win_hit = acc_sum < window_low_threshold_in;
            WIN_ABOVE: win_hit = acc_sum > window_high_threshold_in;
            WIN_INSIDE: win_hit = (acc_sum > window_low_threshold_in)
                && (acc_sum < window_high_threshold_in);
            WIN_OUTSIDE: win_hit = (acc_sum < window_low_threshold_in)
                || (acc_sum > window_high_threshold_in);
            default: win_hit = 1'b0;
        endcase
    end

    // [R16] event start
    assign trig_set = trigger_write_in || (event_trigger_enable_in && event_edge);

    // Sequencer and trigger bit.
    always_comb
    begin
        next_state = state;
        next_cycle = cycle;
        next_acc_count = acc_count;
        next_acc = acc;
        next_trig_bit = trig_bit;
        next_result = result;
        if (trigger_stop_in)
        begin
            next_trig_bit = 1'b0;
        end
        case (state)
            ACS_IDLE:
            begin
                next_cycle = '0;
                next_acc_count = '0;
                if (trig_bit && tick)
                begin
                    next_state = ACS_SAMPLE;
                end
            end
            ACS_SAMPLE, ACS_CONVERT:
            begin
                if (tick)
                begin
                    next_cycle = cycle + CYC_ONE;
                    // [R1] end of sampling
                    if (next_cycle == sample_total)
                    begin
                        next_state = ACS_CONVERT;
                    end
                end
                if (finish)
                begin
                    next_cycle = '0;
                    next_acc = acc_sum;
                    next_acc_count = acc_count + ACNT_W'(1);
                    next_state = ACS_SAMPLE;
                    if (result_done)
                    begin
                        // [R11] result stored with flag
                        next_result = acc_sum;
                        next_acc_count = '0;
                        if (!auto_repeat_mode_in)
                        begin
                            // [R22] clear when done
                            next_trig_bit = 1'b0;
                        end
                        // [R2] repeat while trigger set
                        if (!next_trig_bit)
                        begin
                            next_state = ACS_IDLE;
                        end
                    end
                end
            end
            default:
            begin
                next_state = ACS_IDLE;
            end
        endcase
        if (trig_set)
        begin
            next_trig_bit = 1'b1;
        end
        if (!enable_in)
        begin
            next_state = ACS_IDLE;
            next_trig_bit = 1'b0;
        end
    end

    // Shadow selections, pending flags and interrupt requests.
    always_comb
    begin
        next_active_mux = active_mux;
        next_active_ref = active_ref;
        // [R3] copy from shadow
        // [R4] freeze until last cycle
        // [R7] next conversion keeps old channel
        if (!running || (cycle == last_cycle))
        begin
            next_active_mux = input_select_field_in;
            next_active_ref = reference_select_field_in;
        end
        next_flags = flags;
        // [R21] read or write-one clear
        if (result_read_in || flag_clear_in[FLAG_RESULT_READY_FLAG])
        begin
            next_flags[FLAG_RESULT_READY_FLAG] = 1'b0;
        end
        if (flag_clear_in[FLAG_WIN])
        begin
            next_flags[FLAG_WIN] = 1'b0;
        end
        // [R18] flags set regardless of enable
        if (result_done)
        begin
            next_flags[FLAG_RESULT_READY_FLAG] = 1'b1;
        end
        // [R14] mode non-zero only
        // [R15] once per accumulated result
        if (result_done && window_mode_field_in != WIN_OFF && win_hit)
        begin
            next_flags[FLAG_WIN] = 1'b1;
        end
        // [R19] request while flag and enable
        next_irq_res = next_flags[FLAG_RESULT_READY_FLAG] && irq_enable_register_in[FLAG_RESULT_READY_FLAG];
        next_irq_win = next_flags[FLAG_WIN] && irq_enable_register_in[FLAG_WIN];
        // [R17] vector offsets
        next_irq_vec = next_irq_res ? VEC_RESULT : (next_irq_win ? win_vector : VEC_RESULT);
    end

    assign win_vector = LARGE_FLASH ? VEC_WIN_LARGE : VEC_WIN_SMALL;

    always_ff @(posedge clock_in)
    begin
        if (reset_in)
        begin
            state <= ACS_IDLE;
            cycle <= '0;
            acc_count <= '0;
            acc <= RES_RESET;
            trig_bit <= 1'b0;
            result <= RES_RESET;
            flags <= 2'h0;
            active_mux <= '0;
            active_ref <= REF_INTERNAL;
            irq_res <= 1'b0;
            irq_win <= 1'b0;
            irq_any <= 1'b0;
            irq_vec <= VEC_RESULT;
        end
        else
        begin
            state <= next_state;
            cycle <= next_cycle;
            acc_count <= next_acc_count;
            acc <= next_acc;
            trig_bit <= next_trig_bit;
            result <= next_result;
            flags <= next_flags;
            active_mux <= next_active_mux;
            active_ref <= next_active_ref;
            irq_res <= next_irq_res;
            irq_win <= next_irq_win;
            irq_any <= next_irq_res || next_irq_win;
            irq_vec <= next_irq_vec;
        end
    end

    // Core-facing decodes, registered so every output comes from a flip-flop.
    logic ref_internal;
    logic temp_enable;
    logic core_sample;
    logic core_convert;

    always_ff @(posedge clock_in)
    begin
        if (reset_in)
        begin
            ref_internal <= 1'b1;
            temp_enable <= 1'b0;
            core_sample <= 1'b0;
            core_convert <= 1'b0;
        end
        else
        begin
            // [R9] zero selects internal
            ref_internal <= (next_active_ref == REF_INTERNAL);
            // [R10] temperature sensor on
            temp_enable <= (next_active_mux == TEMP_CHANNEL);
            // [R20] hold after sampling phase
            core_sample <= (next_state == ACS_SAMPLE);
            core_convert <= (next_state == ACS_CONVERT);
        end
    end

    assign active_input_select_out = active_mux;
    assign active_reference_select_out = active_ref;
    assign reference_internal_out = ref_internal;
    assign temp_sensor_enable_out = temp_enable;
    assign core_sample_out = core_sample;
    assign core_convert_out = core_convert;
    assign conversion_trigger_bit_out = trig_bit;
    assign converted_value_out = result;
    assign pending_flags_register_out = flags;
    assign irq_result_ready_out = irq_res;
    assign irq_window_out = irq_win;
    assign irq_request_out = irq_any;
    assign irq_vector_out = irq_vec;

endmodule // acs_sequencer
